// File: design/vid_sel_pkg.sv
package vid_sel_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_INPUT_FORMAT = 8'h00;
  localparam logic [7:0] ADDR_PAGE_SELECT = 8'h0E;
  localparam logic [7:0] ADDR_CONTRAST = 8'h80;
  localparam logic [7:0] ADDR_DEINTERLACE = 8'h81;
  localparam int FMT_LSB = 0;
  localparam int FMT_MSB = 4;
  localparam int SUBMAP_LSB = 5;
  localparam int SUBMAP_MSB = 6;
  localparam int ENHANCE_BIT = 7;
  localparam int DEINT_BIT = 0;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [1:0] SUBMAP_USER = 2'h0;
  localparam logic [1:0] SUBMAP_INTR = 2'h1;
  localparam logic [1:0] SUBMAP_USER2 = 2'h2;
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h20;
  localparam int SLAVE_ADDR_SEL_BIT = 0;
  // ****************************************
  // format codes
  // ****************************************
  localparam logic [4:0] FMT_COMPOSITE_LAST = 5'h07;
  localparam logic [4:0] FMT_YC_FIRST = 5'h08;
  localparam logic [4:0] FMT_COMP_1 = 5'h0C;
  localparam logic [4:0] FMT_COMP_2 = 5'h0D;
  localparam int VARIANT_INPUTS_SMALL = 4;

  typedef enum logic [1:0] {
    KIND_COMPOSITE,
    KIND_YC,
    KIND_COMP,
    KIND_NONE
  } video_kind_t;

  typedef struct packed {
    logic [3:0] luma_sel;
    logic [3:0] chroma_b_sel;
    logic [3:0] chroma_r_sel;
    video_kind_t kind;
    logic [7:0] channel_power;
  } route_t;

  typedef struct packed {
    logic [4:0] input_format;
    logic [1:0] sub_map_select;
    logic [7:0] page_raw;
    logic adaptive_contrast_enhance;
    logic deinterlacer;
    logic [7:0] rd_data;
    logic rd_valid;
    logic addr_hit;
    route_t route;
  } state_t;
endpackage

// File: design/video_input_select_config.sv
`timescale 1ns/10ps
module video_input_select_config #(
  parameter int NUM_INPUTS = 8
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // strap and decoded serial bus access
  input wire logic I_ADDRESS_SELECT_PIN,
  input wire logic [6:0] I_SLAVE_ADDR,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic [7:0] I_SUBADDR,
  input wire logic [7:0] I_WDATA,
  // read back
  output logic [7:0] O_RDATA,
  output logic O_RVALID,
  output logic O_ADDR_HIT,
  // decoder configuration
  output logic [3:0] O_LUMA_SEL,
  output logic [3:0] O_CHROMA_B_SEL,
  output logic [3:0] O_CHROMA_R_SEL,
  output logic [1:0] O_VIDEO_KIND,
  output logic [7:0] O_CHANNEL_POWER,
  output logic [1:0] O_SUB_MAP_SELECT,
  output logic O_ADAPTIVE_CONTRAST_ENHANCE,
  output logic O_DEINTERLACER
);
  // ****************************************
  // routing decode
  // ****************************************
  // one composite input; every other channel is powered down
  function automatic vid_sel_pkg::route_t composite_on(input logic [3:0] ch);
    vid_sel_pkg::route_t r;
    r = '0;
    r.kind = vid_sel_pkg::KIND_COMPOSITE;
    r.luma_sel = ch;
    r.channel_power = 8'h01 << ch;
    return r;
  endfunction

  // luma and chroma on two inputs; chroma travels on the blue-difference field
  function automatic vid_sel_pkg::route_t luma_chroma_on(input logic [3:0] y, c);
    vid_sel_pkg::route_t r;
    r = '0;
    r.kind = vid_sel_pkg::KIND_YC;
    r.luma_sel = y;
    r.chroma_b_sel = c;
    r.channel_power = (8'h01 << y) | (8'h01 << c);
    return r;
  endfunction

  // component on three inputs
  function automatic vid_sel_pkg::route_t component_on(input logic [3:0] y, pb, pr);
    vid_sel_pkg::route_t r;
    r = '0;
    r.kind = vid_sel_pkg::KIND_COMP;
    r.luma_sel = y;
    r.chroma_b_sel = pb;
    r.chroma_r_sel = pr;
    r.channel_power = (8'h01 << y) | (8'h01 << pb) | (8'h01 << pr);
    return r;
  endfunction

  // a table rather than arithmetic on the code, so each reserved hole stays visible
  function automatic vid_sel_pkg::route_t decode_route(input logic [4:0] code);
    vid_sel_pkg::route_t r;
    logic big;
    r = '0;
    r.kind = vid_sel_pkg::KIND_NONE;
    big = (NUM_INPUTS > vid_sel_pkg::VARIANT_INPUTS_SMALL);
    case (code)
      5'h00: begin
        r = composite_on(4'h0);
      end
      5'h01: begin
        r = composite_on(4'h1);
      end
      5'h02: begin
        r = composite_on(4'h2);
      end
      5'h03: begin
        r = composite_on(4'h3);
      end
      5'h04: begin
        if (big) begin
          r = composite_on(4'h4);
        end
      end
      5'h05: begin
        if (big) begin
          r = composite_on(4'h5);
        end
      end
      5'h06: begin
        if (big) begin
          r = composite_on(4'h6);
        end
      end
      5'h07: begin
        if (big) begin
          r = composite_on(4'h7);
        end
      end
      5'h08: begin
        r = luma_chroma_on(4'h0, 4'h1);
      end
      5'h09: begin
        r = luma_chroma_on(4'h2, 4'h3);
      end
      5'h0A: begin
        if (big) begin
          r = luma_chroma_on(4'h4, 4'h5);
        end
      end
      5'h0B: begin
        if (big) begin
          r = luma_chroma_on(4'h6, 4'h7);
        end
      end
      vid_sel_pkg::FMT_COMP_1: begin
        r = component_on(4'h0, 4'h1, 4'h2);
      end
      vid_sel_pkg::FMT_COMP_2: begin
        if (big) begin
          r = component_on(4'h3, 4'h4, 4'h5);
        end
      end
      default: begin
        r.kind = vid_sel_pkg::KIND_NONE;
      end
    endcase
    return r; // reserved codes: no routing, all channels down
  endfunction

  vid_sel_pkg::state_t state;
  vid_sel_pkg::state_t next_state;
  logic [6:0] own_addr;
  logic wr;
  logic rd;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    // ****************************************
    // address match
    // ****************************************
    own_addr = vid_sel_pkg::SLAVE_ADDR_BASE;
    own_addr[vid_sel_pkg::SLAVE_ADDR_SEL_BIT] = I_ADDRESS_SELECT_PIN;
    next_state.addr_hit = (I_SLAVE_ADDR == own_addr);
    wr = I_WR_EN && next_state.addr_hit;
    rd = I_RD_EN && next_state.addr_hit && !I_WR_EN;
    next_state.rd_valid = rd;
    next_state.rd_data = 8'h00;
    // ****************************************
    // register writes
    // ****************************************
    if (wr) begin
      if (I_SUBADDR == vid_sel_pkg::ADDR_PAGE_SELECT) begin
        next_state.page_raw = I_WDATA;
        next_state.sub_map_select = I_WDATA[vid_sel_pkg::SUBMAP_MSB:vid_sel_pkg::SUBMAP_LSB];
      end else if (state.sub_map_select == vid_sel_pkg::SUBMAP_USER) begin
        if (I_SUBADDR == vid_sel_pkg::ADDR_INPUT_FORMAT) begin
          next_state.input_format = I_WDATA[vid_sel_pkg::FMT_MSB:vid_sel_pkg::FMT_LSB];
        end
      end else if (state.sub_map_select == vid_sel_pkg::SUBMAP_USER2) begin
        if (I_SUBADDR == vid_sel_pkg::ADDR_CONTRAST) begin
          next_state.adaptive_contrast_enhance = I_WDATA[vid_sel_pkg::ENHANCE_BIT];
        end else if (I_SUBADDR == vid_sel_pkg::ADDR_DEINTERLACE) begin
          next_state.deinterlacer = I_WDATA[vid_sel_pkg::DEINT_BIT];
        end
      end
    end
    // ****************************************
    // read back; the page register answers on every page
    // ****************************************
    if (rd) begin
      if (I_SUBADDR == vid_sel_pkg::ADDR_PAGE_SELECT) begin
        next_state.rd_data = state.page_raw;
      end else if (state.sub_map_select == vid_sel_pkg::SUBMAP_USER &&
                   I_SUBADDR == vid_sel_pkg::ADDR_INPUT_FORMAT) begin
        next_state.rd_data = {3'h0, state.input_format};
      end else if (state.sub_map_select == vid_sel_pkg::SUBMAP_USER2 &&
                   I_SUBADDR == vid_sel_pkg::ADDR_CONTRAST) begin
        next_state.rd_data = {state.adaptive_contrast_enhance, 7'h00};
      end else if (state.sub_map_select == vid_sel_pkg::SUBMAP_USER2 &&
                   I_SUBADDR == vid_sel_pkg::ADDR_DEINTERLACE) begin
        next_state.rd_data = {7'h00, state.deinterlacer};
      end
    end
    next_state.route = decode_route(next_state.input_format);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= '0;
      // routing after reset matches the table entry for code zero
      state.route.kind <= vid_sel_pkg::KIND_COMPOSITE;
      state.route.channel_power <= 8'h01;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // all outputs are fields of the state flop, so each is registered
  assign O_RDATA = state.rd_data;
  assign O_RVALID = state.rd_valid;
  assign O_ADDR_HIT = state.addr_hit;
  assign O_LUMA_SEL = state.route.luma_sel;
  assign O_CHROMA_B_SEL = state.route.chroma_b_sel;
  assign O_CHROMA_R_SEL = state.route.chroma_r_sel;
  assign O_VIDEO_KIND = state.route.kind;
  assign O_CHANNEL_POWER = state.route.channel_power;
  assign O_SUB_MAP_SELECT = state.sub_map_select;
  assign O_ADAPTIVE_CONTRAST_ENHANCE = state.adaptive_contrast_enhance;
  assign O_DEINTERLACER = state.deinterlacer;
endmodule // video_input_select_config

// File: verif/vid_sel_host.sv
`timescale 1ns/10ps
module vid_sel_host (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] sa,
  output logic [7:0] sub,
  output logic [7:0] wd
);
  initial begin
    {wr_en, rd_en, sa, sub, wd} = '0;
  end
  // one single-byte access; released subaddress and data lines show inverted values, the slave address holds
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] s, d);
    @(negedge clk);
    {wr_en, rd_en, sa, sub, wd} = {w, !w, a, s, d};
    @(negedge clk);
    {wr_en, rd_en, sub, wd} = {2'h0, ~s, ~d};
  endtask
endmodule // vid_sel_host

// File: verif/vid_sel_asserts.sv
`timescale 1ns/10ps
module vid_sel_asserts (
  input wire logic I_SYS_CLK, I_RST, I_ADDRESS_SELECT_PIN, I_WR_EN, I_RD_EN, O_RVALID,
  input wire logic [6:0] I_SLAVE_ADDR,
  input wire logic [7:0] I_SUBADDR, I_WDATA, O_CHANNEL_POWER,
  input wire logic [3:0] O_LUMA_SEL,
  input wire logic [1:0] O_VIDEO_KIND, O_SUB_MAP_SELECT,
  input wire logic O_ADAPTIVE_CONTRAST_ENHANCE, O_DEINTERLACER
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  logic hit;
  logic wr;
  assign hit = I_SLAVE_ADDR == {6'h10, I_ADDRESS_SELECT_PIN};
  assign wr = I_WR_EN && hit;
  a_read_answer: assert property (I_RD_EN && !I_WR_EN && hit |=> O_RVALID)
    else $error("read not answered");
  a_foreign_addr: assert property (I_RD_EN && !hit |=> !O_RVALID)
    else $error("foreign read answered");
  a_page_enter: assert property (wr && I_SUBADDR == 8'h0E && I_WDATA == 8'h40
    |=> O_SUB_MAP_SELECT == 2'h2) else $error("page not entered");
  a_composite_power: assert property (O_VIDEO_KIND == 2'h0
    |-> O_CHANNEL_POWER == 8'h01 << O_LUMA_SEL) else $error("unused channel powered");
  a_reserved_off: assert property (O_VIDEO_KIND == 2'h3 |-> O_CHANNEL_POWER == 8'h00)
    else $error("reserved code powered");
  a_enhance_cause: assert property ($changed(O_ADAPTIVE_CONTRAST_ENHANCE)
    |-> $past(wr && I_SUBADDR == 8'h80 && O_SUB_MAP_SELECT == 2'h2))
    else $error("enhance moved");
  a_deint_cause: assert property ($changed(O_DEINTERLACER)
    |-> $past(wr && I_SUBADDR == 8'h81 && O_SUB_MAP_SELECT == 2'h2))
    else $error("deint moved");
  a_route_cause: assert property ($changed({O_VIDEO_KIND, O_LUMA_SEL})
    |-> $past(wr && I_SUBADDR == 8'h00 && O_SUB_MAP_SELECT == 2'h0))
    else $error("route moved");
  c_read: cover property (O_RVALID);
  c_enhance: cover property ($rose(O_ADAPTIVE_CONTRAST_ENHANCE));
  c_reserved: cover property (O_VIDEO_KIND == 2'h3);
endmodule // vid_sel_asserts
bind video_input_select_config vid_sel_asserts u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_ADDRESS_SELECT_PIN(I_ADDRESS_SELECT_PIN), .I_WR_EN(I_WR_EN), .I_RD_EN(I_RD_EN),
  .O_RVALID(O_RVALID), .I_SLAVE_ADDR(I_SLAVE_ADDR), .I_SUBADDR(I_SUBADDR), .I_WDATA(I_WDATA),
  .O_CHANNEL_POWER(O_CHANNEL_POWER), .O_LUMA_SEL(O_LUMA_SEL), .O_VIDEO_KIND(O_VIDEO_KIND),
  .O_SUB_MAP_SELECT(O_SUB_MAP_SELECT), .O_DEINTERLACER(O_DEINTERLACER),
  .O_ADAPTIVE_CONTRAST_ENHANCE(O_ADAPTIVE_CONTRAST_ENHANCE));

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk, rst, pin, wr, rd, rv, enh, dei, hit;
  logic [6:0] sa;
  logic [7:0] sub, wd, rdat, pwr, pwr_s, r;
  logic [3:0] lu, cb, cr;
  logic [1:0] kind, kind_s, smap;
  logic [13:0] e;
  logic [7:0] expq[$];
  int n_errors = 0;
  int check_count = 0;
  vid_sel_host host (.clk(clk), .wr_en(wr), .rd_en(rd), .sa(sa), .sub(sub), .wd(wd));
  video_input_select_config DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_ADDRESS_SELECT_PIN(pin),
    .I_SLAVE_ADDR(sa), .I_WR_EN(wr), .I_RD_EN(rd), .I_SUBADDR(sub), .I_WDATA(wd),
    .O_RDATA(rdat), .O_RVALID(rv), .O_ADDR_HIT(hit), .O_LUMA_SEL(lu), .O_CHROMA_B_SEL(cb),
    .O_CHROMA_R_SEL(cr), .O_VIDEO_KIND(kind), .O_CHANNEL_POWER(pwr), .O_SUB_MAP_SELECT(smap),
    .O_ADAPTIVE_CONTRAST_ENHANCE(enh), .O_DEINTERLACER(dei));
  // four-input variant on the same bus, to see its reserved holes
  video_input_select_config #(.NUM_INPUTS(4)) DUT_SMALL (.I_SYS_CLK(clk), .I_RST(rst),
    .I_ADDRESS_SELECT_PIN(pin), .I_SLAVE_ADDR(sa), .I_WR_EN(wr), .I_RD_EN(rd),
    .I_SUBADDR(sub), .I_WDATA(wd), .O_RDATA(), .O_RVALID(), .O_ADDR_HIT(), .O_LUMA_SEL(),
    .O_CHROMA_B_SEL(), .O_CHROMA_R_SEL(), .O_VIDEO_KIND(kind_s), .O_CHANNEL_POWER(pwr_s),
    .O_SUB_MAP_SELECT(), .O_ADAPTIVE_CONTRAST_ENHANCE(), .O_DEINTERLACER());
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr1(input logic [7:0] s, d);
    host.xfer(1, {6'h10, pin}, s, d);
  endtask
  task automatic rd1(input logic [7:0] s, e);
    expq.push_back(e);
    host.xfer(0, {6'h10, pin}, s, 8'h00);
  endtask
  // expected {kind, luma, chroma b, chroma r}
  function automatic logic [13:0] route(input int c);
    if (c < 8) return {2'h0, 4'(c), 8'h00};
    if (c < 12) return {2'h1, 4'(2 * c - 16), 4'(2 * c - 15), 4'h0};
    if (c < 14) return {2'h2, 4'(3 * c - 36), 4'(3 * c - 35), 4'(3 * c - 34)};
    return {2'h3, 12'h000};
  endfunction
  // inputs in use for each code, bit n for input n
  function automatic logic [7:0] power(input int c);
    if (c < 8) return 8'h01 << c;
    if (c < 12) return 8'h03 << (2 * c - 16);
    if (c == 12) return 8'h07;
    if (c == 13) return 8'h38;
    return 8'h00;
  endfunction
  // codes with no routing on the four-input variant
  function automatic logic small_rsv(input int c);
    return (c >= 4 && c < 8) || c == 10 || c == 11 || c > 12;
  endfunction
  always @(negedge clk) begin
    if (rv === 1'b1) chk(rdat, expq.size() > 0 ? expq.pop_front() : ~rdat);
  end
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    #5000000;
    n_errors++;
    wrap_up();
  end
  initial begin
    {rst, pin} = 2'h2;
    void'($urandom(35898));
    repeat (6) @(negedge clk);
    rst = 0;
    chk({enh, dei, kind, pwr, smap}, 14'h0004);
    for (int c = 0; c < 32; c++) begin
      r = 8'($urandom);
      e = route(c);
      wr1(8'h00, {r[7:5], 5'(c)});
      chk({kind, lu, cb, cr}, e);
      chk(pwr, power(c));
      chk({kind_s, pwr_s}, small_rsv(c) ? {2'h3, 8'h00} : {e[13:12], power(c)});
      rd1(8'h00, {3'h0, 5'(c)});
    end
    pin = 1;
    // old address now belongs to another device
    host.xfer(1, 7'h20, 8'h00, 8'h05);
    chk(kind, 2'h3);
    host.xfer(0, 7'h20, 8'h00, 8'h00);
    chk(hit, 1'b0);
    wr1(8'h0E, 8'h40);
    chk({hit, smap}, 3'h6);
    rd1(8'h80, 8'h00);
    wr1(8'h80, 8'h80);
    wr1(8'h81, 8'h01);
    chk({enh, dei}, 2'h3);
    wr1(8'h0E, 8'h00);
    chk({smap, enh}, 3'h1);
    rd1(8'h80, 8'h00);
    wr1(8'h0E, 8'h20);
    chk(smap, 2'h1);
    wr1(8'h80, 8'h00);
    chk(enh, 1'b1);
    wr1(8'h0E, 8'h40);
    wr1(8'h80, 8'h00);
    wr1(8'h0E, 8'h00);
    chk({smap, enh, dei}, 4'h1);
    rst = 1;
    @(negedge clk);
    rst = 0;
    chk({dei, kind, pwr}, 11'h001);
    for (int i = 0; i < 5 && expq.size() > 0; i++) @(negedge clk);
    if (expq.size() > 0) n_errors++;
    wrap_up();
  end
endmodule // testbench
